// ---- logic/acpe_alarm_pio.sv ----
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module acpe_alarm_pio #(
  parameter int RES_HOLD_CYC = acpe_pkg::RES_HOLD_CYC
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Controller pins
  input  wire logic        cur_pos_write_in,
  input  wire logic        alarm_reset_in,
  output logic             alarm_n_out,
  output logic             pos_done_bit0,
  output logic             pos_done_bit1,
  output logic             pos_done_bit2,
  output logic             pos_done_bit3,
  output logic             home_done_out,
  // Motion core status, same clock
  input  wire logic [3:0]  pos_num_in,
  input  wire logic        jog_active_in,
  input  wire logic        moving_in,
  input  wire logic        home_done_in,
  input  wire logic        speed_change_in,
  input  wire logic [15:0] cur_pos_in
);

  localparam int CW = $clog2(RES_HOLD_CYC + 1);

  logic [4:0]        ctrl_ff,   nxt_ctrl;
  logic [15:0]       lim_lo_ff, nxt_lim_lo;
  logic [15:0]       lim_hi_ff, nxt_lim_hi;
  logic [15:0]       stop_ff,   nxt_stop;
  logic [17:0]       move_ff,   nxt_move;
  logic              spd_ff,    nxt_spd;
  logic              bad_ff,    nxt_bad;
  logic              act_ff,    nxt_act;
  logic [11:0]       code_ff,   nxt_code;
  logic [CW-1:0]     cnt_ff,    nxt_cnt;
  logic [31:0]       prdata_ff, nxt_prdata;
  logic              pready_ff, nxt_pready;
  logic              perr_ff,   nxt_perr;
  logic              home_ff;
  acpe_pkg::acpe_pio_t pio_ff,  nxt_pio;
  logic [2:0]        cur_pos_write_in_sy_ff;
  logic [1:0]        res_sy_ff;
  logic [3:0]        grp;
  logic [3:0]        grp_cur;
  logic [31:0]       rdat;
  logic              rbad;
  logic              acc, wr, mv_wr, cur_pos_write_in_rise, teach, pat_ok, prm_bad;
  logic              ev_092, ev_093, ev_0a1, ev_0a2, ev_0a7, ev_raise, hit, clr;
  logic [11:0]       ev_code;
  logic [16:0]       room;
  logic              tgt_out;

  // Pin inputs cross two flops; edge detect looks only at the second onward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_pos_write_in_sy_ff <= 3'h0;
      res_sy_ff  <= 2'h0;
    end else begin
      cur_pos_write_in_sy_ff <= {cur_pos_write_in_sy_ff[1:0], cur_pos_write_in};
      res_sy_ff  <= {res_sy_ff[0], alarm_reset_in};
    end
  end

  // Access phase completes on the second access cycle
  assign acc   = psel & penable & pready_ff;
  assign wr    = acc & pwrite;
  assign mv_wr = wr & (paddr == acpe_pkg::OFS_MOVE);
  assign teach = ctrl_ff[acpe_pkg::CTRL_TEACH_BIT];
  assign pat_ok = ctrl_ff[acpe_pkg::CTRL_PAT_LSB +: 3] <= acpe_pkg::PAT_ALM_MAX;
  assign cur_pos_write_in_rise = cur_pos_write_in_sy_ff[1] & ~cur_pos_write_in_sy_ff[2];

  // Teach-mode write misuse; jogging takes precedence over homing
  assign ev_092 = teach & cur_pos_write_in_rise & jog_active_in;                    // RULE16
  assign ev_093 = teach & cur_pos_write_in_rise & ~jog_active_in & ~home_done_in;   // RULE17

  // Limit pair checked on its rising inconsistency only
  assign prm_bad = lim_lo_ff > lim_hi_ff;
  assign ev_0a1  = prm_bad & ~bad_ff;                                   // RULE19

  // Move target checks; incremental targets skip the limit test
  assign tgt_out = ~pwdata[acpe_pkg::MOVE_INC_BIT]
                 & ((pwdata[15:0] > lim_hi_ff) | (pwdata[15:0] < lim_lo_ff));
  assign ev_0a2 = mv_wr & (~pwdata[acpe_pkg::MOVE_VLD_BIT] | tgt_out     // RULE20
                 | (pwdata[acpe_pkg::MOVE_INC_BIT] & ctrl_ff[acpe_pkg::CTRL_3PT_BIT]));

  // Room to the upper limit; negative room also trips
  assign room   = {1'b0, lim_hi_ff} - {1'b0, cur_pos_in};
  assign ev_0a7 = mv_wr & moving_in & spd_ff                             // RULE21
                & (room[16] | (room[15:0] < stop_ff));

  // Alarms raised by other controller sections
  assign ev_raise = wr & (paddr == acpe_pkg::OFS_RAISE)
                  & (pwdata[11:0] != acpe_pkg::C_NONE);

  // One winner per cycle; across cycles the newest one wins
  always_comb begin
    if (ev_092) begin
      ev_code = acpe_pkg::C_092;
    end else if (ev_093) begin
      ev_code = acpe_pkg::C_093;
    end else if (ev_0a7) begin
      ev_code = acpe_pkg::C_0A7;
    end else if (ev_0a2) begin
      ev_code = acpe_pkg::C_0A2;
    end else if (ev_0a1) begin
      ev_code = acpe_pkg::C_0A1;
    end else begin
      ev_code = pwdata[11:0];
    end
  end
  assign hit = ev_092 | ev_093 | ev_0a7 | ev_0a2 | ev_0a1 | ev_raise;
  assign clr = res_sy_ff[1] & (cnt_ff == CW'(RES_HOLD_CYC - 1));          // RULE23

  acpe_grp_enc u_enc (
    .code (nxt_code),
    .grp  (grp)
  );

  acpe_grp_enc u_enc_cur (
    .code (code_ff),
    .grp  (grp_cur)
  );

  // Read mux and unmapped address decode
  always_comb begin
    rdat = 32'h0000_0000;
    rbad = 1'b0;
    if (paddr == acpe_pkg::OFS_CTRL) begin
      rdat[4:0] = ctrl_ff;
    end else if (paddr == acpe_pkg::OFS_LIM_LO) begin
      rdat[15:0] = lim_lo_ff;
    end else if (paddr == acpe_pkg::OFS_LIM_HI) begin
      rdat[15:0] = lim_hi_ff;
    end else if (paddr == acpe_pkg::OFS_STOP) begin
      rdat[15:0] = stop_ff;
    end else if (paddr == acpe_pkg::OFS_MOVE) begin
      rdat[17:0] = move_ff;
    end else if (paddr == acpe_pkg::OFS_RAISE) begin
      rdat = 32'h0000_0000;
    end else if (paddr == acpe_pkg::OFS_STATUS) begin
      rdat[11:0] = code_ff;
      rdat[acpe_pkg::STAT_ACT_BIT] = act_ff;
      rdat[acpe_pkg::STAT_GRP_LSB +: 4] = grp_cur;
      rdat[acpe_pkg::STAT_HOME_BIT] = home_ff;
    end else begin
      rbad = 1'b1;
    end
  end

  // Next state of bus, registers, alarm latch and lines
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_lim_lo = lim_lo_ff;
    nxt_lim_hi = lim_hi_ff;
    nxt_stop   = stop_ff;
    nxt_move   = move_ff;
    nxt_pready = psel & penable & ~pready_ff;
    nxt_prdata = nxt_pready ? rdat : 32'h0000_0000;
    nxt_perr   = nxt_pready & rbad;
    if (wr && !rbad) begin
      if (paddr == acpe_pkg::OFS_CTRL) begin
        nxt_ctrl = pwdata[4:0];
      end else if (paddr == acpe_pkg::OFS_LIM_LO) begin
        nxt_lim_lo = pwdata[15:0];
      end else if (paddr == acpe_pkg::OFS_LIM_HI) begin
        nxt_lim_hi = pwdata[15:0];
      end else if (paddr == acpe_pkg::OFS_STOP) begin
        nxt_stop = pwdata[15:0];
      end else if (paddr == acpe_pkg::OFS_MOVE) begin
        nxt_move = pwdata[17:0];
      end
    end
    // Speed change flag: new change wins over the consuming move
    nxt_spd = speed_change_in | (spd_ff & ~mv_wr);
    nxt_bad = prm_bad;
    // Reset hold counter saturates so one hold clears once
    if (!res_sy_ff[1]) begin
      nxt_cnt = '0;
    end else if (cnt_ff != CW'(RES_HOLD_CYC)) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else begin
      nxt_cnt = cnt_ff;
    end
    // A new alarm beats a clear in the same cycle
    nxt_act  = hit | (act_ff & ~clr);                                    // RULE22
    nxt_code = hit ? ev_code : (clr ? acpe_pkg::C_NONE : code_ff);       // RULE24
    nxt_pio.alarm_n = ~nxt_act;                                          // RULE3
    nxt_pio.pos = (nxt_act && pat_ok) ? grp : pos_num_in;                // RULE1
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= acpe_pkg::CTRL_RST;
      lim_lo_ff <= acpe_pkg::LIM_LO_RST;
      lim_hi_ff <= acpe_pkg::LIM_HI_RST;
      stop_ff   <= acpe_pkg::STOP_RST;
      move_ff   <= 18'h0_0000;
      spd_ff    <= 1'b0;
      bad_ff    <= 1'b0;
      act_ff    <= 1'b0;
      code_ff   <= acpe_pkg::C_NONE;
      cnt_ff    <= '0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      perr_ff   <= 1'b0;
      home_ff   <= 1'b0;
      pio_ff    <= '{alarm_n: 1'b1, pos: 4'h0};
    end else begin
      ctrl_ff   <= nxt_ctrl;
      lim_lo_ff <= nxt_lim_lo;
      lim_hi_ff <= nxt_lim_hi;
      stop_ff   <= nxt_stop;
      move_ff   <= nxt_move;
      spd_ff    <= nxt_spd;
      bad_ff    <= nxt_bad;
      act_ff    <= nxt_act;
      code_ff   <= nxt_code;
      cnt_ff    <= nxt_cnt;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      perr_ff   <= nxt_perr;
      home_ff   <= home_done_in;
      pio_ff    <= nxt_pio;
    end
  end

  // Outputs, all from flops
  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = perr_ff;
  assign alarm_n_out   = pio_ff.alarm_n;
  assign pos_done_bit0 = pio_ff.pos[0];
  assign pos_done_bit1 = pio_ff.pos[1];
  assign pos_done_bit2 = pio_ff.pos[2];
  assign pos_done_bit3 = pio_ff.pos[3];
  assign home_done_out = home_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Lines hold the alarm group when the pattern allows it
  sequence s_shown(logic [3:0] g);
    $past(pat_ok) ##0 !alarm_n_out ##0 (pio_ff.pos == g);
  endsequence
  property p_grp(logic [11:0] c, logic [3:0] g);
    (act_ff && code_ff == c && $past(pat_ok)) |-> s_shown(g);
  endproperty
  a_rule4: assert property (p_grp(acpe_pkg::C_093, acpe_pkg::G_TEACH)) // RULE4
    else $error("093 group wrong");
  a_rule5: assert property (p_grp(acpe_pkg::C_0A7, acpe_pkg::G_DECEL)) // RULE5
    else $error("0A7 group wrong");
  a_rule6: assert property (p_grp(acpe_pkg::C_0F4, acpe_pkg::G_BOARD)) // RULE6
    else $error("0F4 group wrong");
  a_rule7: assert property (p_grp(acpe_pkg::C_0A2, acpe_pkg::G_DATA)) // RULE7
    else $error("0A2 group wrong");
  a_rule9: assert property (p_grp(acpe_pkg::C_0C0, acpe_pkg::G_SPEED)) // RULE9
    else $error("0C0 group wrong");
  a_rule15: assert property (p_grp(acpe_pkg::C_0F8, acpe_pkg::G_NVM)) // RULE15
    else $error("0F8 group wrong");

  // Other patterns keep the completed position on the lines
  property p_pat_gate;
    (!pat_ok && nxt_act) |=> (pio_ff.pos == $past(pos_num_in)) && !alarm_n_out;
  endproperty
  a_pat_gate: assert property (p_pat_gate) // RULE1
    else $error("alarm group shown in wrong pattern");

  property p_idle;
    !nxt_act |=> alarm_n_out && (pio_ff.pos == $past(pos_num_in));
  endproperty
  a_idle: assert property (p_idle) // RULE3
    else $error("lines wrong with no alarm");

  property p_jog;
    ev_092 |=> (code_ff == acpe_pkg::C_092) ##0 !alarm_n_out;
  endproperty
  a_jog: assert property (p_jog) // RULE16
    else $error("092 not raised");

  property p_home;
    (teach && cur_pos_write_in_rise && !jog_active_in && !home_done_in) |=> code_ff == acpe_pkg::C_093;
  endproperty
  a_home: assert property (p_home) // RULE17
    else $error("093 not raised");

  property p_prm;
    ($rose(prm_bad) && !ev_092 && !ev_093 && !mv_wr) |=> code_ff == acpe_pkg::C_0A1;
  endproperty
  a_prm: assert property (p_prm) // RULE19
    else $error("0A1 not raised");

  property p_move;
    (mv_wr && !pwdata[acpe_pkg::MOVE_VLD_BIT] && !ev_092 && !ev_093 && !ev_0a7)
      |=> code_ff == acpe_pkg::C_0A2;
  endproperty
  a_move: assert property (p_move) // RULE20
    else $error("0A2 not raised");

  property p_decel;
    (ev_0a7 && !ev_092 && !ev_093) |=> code_ff == acpe_pkg::C_0A7;
  endproperty
  a_decel: assert property (p_decel) // RULE21
    else $error("0A7 not raised");

  property p_alarm_off;
    hit |=> !alarm_n_out ##1 (!alarm_n_out || $past(clr));
  endproperty
  a_alarm_off: assert property (p_alarm_off) // RULE22
    else $error("alarm line not OFF");

  // Release comes only after the full hold
  sequence s_held;
    act_ff && res_sy_ff[1] && (cnt_ff == CW'(RES_HOLD_CYC - 1)) && !hit;
  endsequence
  property p_reset;
    s_held |=> alarm_n_out && !act_ff;
  endproperty
  a_reset: assert property (p_reset) // RULE23
    else $error("alarm not cleared after hold");

  property p_early;
    (act_ff && !(res_sy_ff[1] && cnt_ff == CW'(RES_HOLD_CYC - 1))) |=> act_ff;
  endproperty
  a_early: assert property (p_early) // RULE23
    else $error("alarm cleared early");

  property p_newest;
    hit |=> code_ff == $past(ev_code);
  endproperty
  a_newest: assert property (p_newest) // RULE24
    else $error("newest alarm not kept");

endmodule : acpe_alarm_pio

// ---- logic/acpe_grp_enc.sv ----
`timescale 1ns/1ps
module acpe_grp_enc (
  // Alarm code in, group out
  input  wire logic [11:0] code,
  output logic      [3:0]  grp
);

  // Unknown codes map to zero; no such code is raised internally
  always_comb begin
    case (code)
      acpe_pkg::C_092, acpe_pkg::C_093: grp = acpe_pkg::G_TEACH;       // RULE4
      acpe_pkg::C_0A7: grp = acpe_pkg::G_DECEL;                        // RULE5
      acpe_pkg::C_0F4: grp = acpe_pkg::G_BOARD;                        // RULE6
      acpe_pkg::C_0A1, acpe_pkg::C_0A2: grp = acpe_pkg::G_DATA;        // RULE7
      acpe_pkg::C_0B8, acpe_pkg::C_0BA, acpe_pkg::C_0BE: grp = acpe_pkg::G_HOME; // RULE8
      acpe_pkg::C_0C0: grp = acpe_pkg::G_SPEED;                        // RULE9
      acpe_pkg::C_0C9, acpe_pkg::C_0CA, acpe_pkg::C_0CC,
      acpe_pkg::C_0CE: grp = acpe_pkg::G_SUPPLY;                       // RULE10
      acpe_pkg::C_0D8, acpe_pkg::C_0DC, acpe_pkg::C_0D9: grp = acpe_pkg::G_DEV; // RULE11
      acpe_pkg::C_0C1: grp = acpe_pkg::G_SERVO;                        // RULE12
      acpe_pkg::C_0E8, acpe_pkg::C_0E9, acpe_pkg::C_0EA: grp = acpe_pkg::G_ENC; // RULE13
      acpe_pkg::C_0FA: grp = acpe_pkg::G_CPU;                          // RULE14
      acpe_pkg::C_0F5, acpe_pkg::C_0F6, acpe_pkg::C_0F8: grp = acpe_pkg::G_NVM; // RULE15
      default: grp = acpe_pkg::G_NONE;
    endcase
  end

endmodule : acpe_grp_enc

// ---- logic/acpe_pkg.sv ----
// Function
// [RULE1] Alarm group on lines only in patterns 0-3
// [RULE2] Host tells position from alarm by alarm line
// [RULE3] No alarm: alarm line ON, lines show position
// [RULE4] Alarms 092/093 give group 0010
// [RULE5] Alarm 0A7 gives group 0011
// [RULE6] Alarm 0F4 gives group 0100
// [RULE7] Alarms 0A1/0A2 give group 0110
// [RULE8] Alarms 0B8/0BA/0BE give group 0111
// [RULE9] Alarm 0C0 gives group 1000
// [RULE10] Supply and overheat alarms give group 1001
// [RULE11] Deviation, push, stroke alarms give group 1011
// [RULE12] Alarm 0C1 gives group 1100
// [RULE13] Encoder disconnection alarms give group 1101
// [RULE14] Alarm 0FA gives group 1110
// [RULE15] Nonvolatile memory alarms give group 1111
// [RULE16] Teach write while jogging raises 092
// [RULE17] Teach write before homing raises 093
// [RULE18] Host writes only when stopped and homed
// [RULE19] Inconsistent limit pair raises 0A1
// [RULE20] Bad move target raises 0A2
// [RULE21] Late move after speed change raises 0A7
// [RULE22] Alarm line active low, OFF on alarm
// [RULE23] Reset held 6 ms clears the alarm
// [RULE24] Newest alarm shown, position restored on clear
package acpe_pkg;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_LIM_LO = 8'h04;
  localparam logic [7:0]  OFS_LIM_HI = 8'h08;
  localparam logic [7:0]  OFS_STOP   = 8'h0C;
  localparam logic [7:0]  OFS_MOVE   = 8'h10;
  localparam logic [7:0]  OFS_RAISE  = 8'h14;
  localparam logic [7:0]  OFS_STATUS = 8'h18;

  // Field positions
  localparam int CTRL_PAT_LSB   = 0;
  localparam int CTRL_TEACH_BIT = 3;
  localparam int CTRL_3PT_BIT   = 4;
  localparam int MOVE_VLD_BIT   = 16;
  localparam int MOVE_INC_BIT   = 17;
  localparam int STAT_ACT_BIT   = 12;
  localparam int STAT_GRP_LSB   = 13;
  localparam int STAT_HOME_BIT  = 17;

  // Reset values and limits
  localparam logic [4:0]  CTRL_RST   = 5'h00;
  localparam logic [15:0] LIM_LO_RST = 16'h0000;
  localparam logic [15:0] LIM_HI_RST = 16'hFFFF;
  localparam logic [15:0] STOP_RST   = 16'h0000;
  localparam logic [2:0]  PAT_ALM_MAX = 3'h3;

  // Alarm codes
  localparam logic [11:0] C_NONE = 12'h000;
  localparam logic [11:0] C_092 = 12'h092;
  localparam logic [11:0] C_093 = 12'h093;
  localparam logic [11:0] C_0A1 = 12'h0A1;
  localparam logic [11:0] C_0A2 = 12'h0A2;
  localparam logic [11:0] C_0A7 = 12'h0A7;
  localparam logic [11:0] C_0B8 = 12'h0B8;
  localparam logic [11:0] C_0BA = 12'h0BA;
  localparam logic [11:0] C_0BE = 12'h0BE;
  localparam logic [11:0] C_0C0 = 12'h0C0;
  localparam logic [11:0] C_0C1 = 12'h0C1;
  localparam logic [11:0] C_0C9 = 12'h0C9;
  localparam logic [11:0] C_0CA = 12'h0CA;
  localparam logic [11:0] C_0CC = 12'h0CC;
  localparam logic [11:0] C_0CE = 12'h0CE;
  localparam logic [11:0] C_0D8 = 12'h0D8;
  localparam logic [11:0] C_0D9 = 12'h0D9;
  localparam logic [11:0] C_0DC = 12'h0DC;
  localparam logic [11:0] C_0E8 = 12'h0E8;
  localparam logic [11:0] C_0E9 = 12'h0E9;
  localparam logic [11:0] C_0EA = 12'h0EA;
  localparam logic [11:0] C_0F4 = 12'h0F4;
  localparam logic [11:0] C_0F5 = 12'h0F5;
  localparam logic [11:0] C_0F6 = 12'h0F6;
  localparam logic [11:0] C_0F8 = 12'h0F8;
  localparam logic [11:0] C_0FA = 12'h0FA;

  // Group codes on lines, weights 8,4,2,1
  localparam logic [3:0] G_NONE  = 4'h0;
  localparam logic [3:0] G_TEACH = 4'h2;
  localparam logic [3:0] G_DECEL = 4'h3;
  localparam logic [3:0] G_BOARD = 4'h4;
  localparam logic [3:0] G_DATA  = 4'h6;
  localparam logic [3:0] G_HOME  = 4'h7;
  localparam logic [3:0] G_SPEED = 4'h8;
  localparam logic [3:0] G_SUPPLY = 4'h9;
  localparam logic [3:0] G_DEV   = 4'hB;
  localparam logic [3:0] G_SERVO = 4'hC;
  localparam logic [3:0] G_ENC   = 4'hD;
  localparam logic [3:0] G_CPU   = 4'hE;
  localparam logic [3:0] G_NVM   = 4'hF;

  // Alarm reset hold time
  localparam int CLK_NS       = 8;
  localparam int RES_HOLD_MS  = 6;
  localparam int RES_HOLD_CYC = (RES_HOLD_MS * 1000000 + CLK_NS - 1) / CLK_NS;

  // Parallel output lines
  typedef struct packed {
    logic       alarm_n;
    logic [3:0] pos;
  } acpe_pio_t;

endpackage : acpe_pkg

// ---- verif/acpe_plc_model.sv ----
`timescale 1ns/1ps
// Host controller that reads the alarm and position lines and drives the write and reset pins
module acpe_plc_model (
  // Clock
  input  wire logic       pclk,
  // Lines from the controller
  input  wire logic       alarm_n_out,
  input  wire logic [3:0] pos_lines,
  input  wire logic       home_done_out,
  input  wire logic       moving,
  // Pins to the controller
  output logic            cur_pos_write_in,
  output logic            alarm_reset_in,
  // Decoded view of the lines
  output logic            alarm_seen,
  output logic [3:0]      value_seen
);
  // Alarm line decides what the four lines mean
  assign alarm_seen = ~alarm_n_out;
  assign value_seen = pos_lines;

  // Pins idle low
  initial begin
    cur_pos_write_in = 1'b0;
    alarm_reset_in   = 1'b0;
  end

  // Write pulse; careful mode waits until stopped and homed
  task automatic write_pos(input bit careful);
    int n = 0;
    while (careful && (moving || !home_done_out) && n < 100) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    cur_pos_write_in <= 1'b1;
    // Held long enough to cross the input synchroniser
    repeat (4) @(posedge pclk);
    cur_pos_write_in <= 1'b0;
  endtask : write_pos

  // Reset press; hold 0 keeps it until the alarm line is back on
  task automatic reset_alarm(input int hold);
    int n = 0;
    @(posedge pclk);
    alarm_reset_in <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while ((hold == 0) ? (alarm_n_out !== 1'b1 && n < 200) : (n < hold));
    alarm_reset_in <= 1'b0;
  endtask : reset_alarm
endmodule : acpe_plc_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  // Short reset hold keeps each clear to a few dozen cycles
  localparam int HOLD = 16;
  // Group nibble above a raised code, one entry per documented code
  localparam logic [15:0] TBL [25] = '{16'h2092, 16'h2093, 16'h30A7, 16'h40F4, 16'h60A1,
    16'h60A2, 16'h70B8, 16'h70BA, 16'h70BE, 16'h80C0, 16'h90C9, 16'h90CA, 16'h90CC,
    16'h90CE, 16'hB0D8, 16'hB0DC, 16'hB0D9, 16'hC0C1, 16'hD0E8, 16'hD0E9, 16'hD0EA,
    16'hE0FA, 16'hF0F5, 16'hF0F6, 16'hF0F8};
  // Bad move commands: unset, past upper, past lower, incremental
  localparam logic [31:0] MV [4] = '{32'h0000_0300, 32'h0001_0900, 32'h0001_0050,
    32'h0003_0300};
  logic               pclk = 1'b0;
  logic               presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               cur_pos_write_in, alarm_reset_in, alarm_n_out, home_done_out;
  logic               pos_done_bit0, pos_done_bit1, pos_done_bit2, pos_done_bit3;
  logic [3:0]         pos_num_in;
  logic               jog_active_in, moving_in, home_done_in, speed_change_in;
  logic [15:0]        cur_pos_in;
  acpe_pkg::acpe_pio_t pins;
  int                 fails = 0;
  int                 checks_done = 0;
  int                 cyc = 0;

  assign pins = {alarm_n_out, pos_done_bit3, pos_done_bit2, pos_done_bit1, pos_done_bit0};

  // Clock
  always #4 pclk = ~pclk;

  acpe_alarm_pio #(.RES_HOLD_CYC(HOLD)) i_acpe_alarm_pio (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cur_pos_write_in(cur_pos_write_in), .alarm_reset_in(alarm_reset_in),
    .alarm_n_out(alarm_n_out), .pos_done_bit0(pos_done_bit0), .pos_done_bit1(pos_done_bit1),
    .pos_done_bit2(pos_done_bit2), .pos_done_bit3(pos_done_bit3),
    .home_done_out(home_done_out), .pos_num_in(pos_num_in), .jog_active_in(jog_active_in),
    .moving_in(moving_in), .home_done_in(home_done_in), .speed_change_in(speed_change_in),
    .cur_pos_in(cur_pos_in));

  acpe_plc_model i_acpe_plc_model (
    .pclk(pclk), .alarm_n_out(alarm_n_out),
    .pos_lines({pos_done_bit3, pos_done_bit2, pos_done_bit1, pos_done_bit0}),
    .home_done_out(home_done_out), .moving(moving_in), .cur_pos_write_in(cur_pos_write_in),
    .alarm_reset_in(alarm_reset_in), .alarm_seen(), .value_seen());

  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d, errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_pins(input string what, input acpe_pkg::acpe_pio_t exp);
    checks_done++;
    if (pins !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, pins);
    end
  endtask : cmp_pins

  // One APB transfer; waits for pready however long it takes
  task automatic apb_rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_rw

  // Alarm shown, status agrees, then a full reset press restores position
  task automatic chk_alarm(input logic [11:0] code, input logic [3:0] grp, input logic keep);
    repeat (4) @(posedge pclk);
    cmp_pins("alarm lines", {1'b0, keep ? pos_num_in : grp});
    apb_rw(1'b0, acpe_pkg::OFS_STATUS, 32'h0000_0000);
    cmp_word("status", {14'h0000, home_done_in, grp, 1'b1, code}, rd);
    i_acpe_plc_model.reset_alarm(0);
    @(posedge pclk);
    cmp_pins("restored lines", {1'b1, pos_num_in});
  endtask : chk_alarm

  // Hang guard, far above the expected run of about 1300 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {jog_active_in, moving_in, speed_change_in, cur_pos_in} = '0;
    home_done_in = 1'b1;
    pos_num_in = 4'h5;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    cmp_pins("idle lines", {1'b1, 4'h5});
    cmp_word("home line", 32'h0000_0001, {31'h0000_0000, home_done_out});
    apb_rw(1'b0, acpe_pkg::OFS_LIM_HI, 32'h0000_0000);
    cmp_word("upper limit reset", 32'h0000_FFFF, rd);
    apb_rw(1'b0, 8'h1C, 32'h0000_0000);
    cmp_word("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    foreach (TBL[i]) begin
      apb_rw(1'b1, acpe_pkg::OFS_RAISE, {20'h0_0000, TBL[i][11:0]});
      chk_alarm(TBL[i][11:0], TBL[i][15:12], 1'b0);
    end
    // Short press must not clear
    apb_rw(1'b1, acpe_pkg::OFS_RAISE, 32'h0000_00C0);
    i_acpe_plc_model.reset_alarm(5);
    repeat (HOLD + 6) @(posedge pclk);
    cmp_pins("short reset", {1'b0, 4'h8});
    apb_rw(1'b1, acpe_pkg::OFS_RAISE, 32'h0000_00FA);
    chk_alarm(12'h0FA, 4'hE, 1'b0);
    // Pattern 3 still shows the group, pattern 4 keeps the position
    apb_rw(1'b1, acpe_pkg::OFS_CTRL, 32'h0000_0003);
    apb_rw(1'b1, acpe_pkg::OFS_RAISE, 32'h0000_00C1);
    chk_alarm(12'h0C1, 4'hC, 1'b0);
    apb_rw(1'b1, acpe_pkg::OFS_CTRL, 32'h0000_0004);
    apb_rw(1'b1, acpe_pkg::OFS_RAISE, 32'h0000_00C1);
    chk_alarm(12'h0C1, 4'hC, 1'b1);
    // Teach mode writes
    apb_rw(1'b1, acpe_pkg::OFS_CTRL, 32'h0000_0008);
    i_acpe_plc_model.write_pos(1'b1);
    repeat (6) @(posedge pclk);
    cmp_pins("legal write", {1'b1, 4'h5});
    jog_active_in <= 1'b1;
    i_acpe_plc_model.write_pos(1'b0);
    chk_alarm(12'h092, 4'h2, 1'b0);
    jog_active_in <= 1'b0;
    home_done_in <= 1'b0;
    i_acpe_plc_model.write_pos(1'b0);
    chk_alarm(12'h093, 4'h2, 1'b0);
    home_done_in <= 1'b1;
    // Move targets against limits, 3-point type on
    apb_rw(1'b1, acpe_pkg::OFS_CTRL, 32'h0000_0010);
    // Teach mode now off: a write while jogging must raise nothing
    jog_active_in <= 1'b1;
    i_acpe_plc_model.write_pos(1'b0);
    repeat (4) @(posedge pclk);
    cmp_pins("write outside teach", {1'b1, 4'h5});
    jog_active_in <= 1'b0;
    apb_rw(1'b1, acpe_pkg::OFS_LIM_LO, 32'h0000_0100);
    apb_rw(1'b1, acpe_pkg::OFS_LIM_HI, 32'h0000_0800);
    foreach (MV[i]) begin
      apb_rw(1'b1, acpe_pkg::OFS_MOVE, MV[i]);
      chk_alarm(12'h0A2, 4'h6, 1'b0);
    end
    apb_rw(1'b1, acpe_pkg::OFS_MOVE, 32'h0001_0300);
    repeat (4) @(posedge pclk);
    cmp_pins("good move", {1'b1, 4'h5});
    apb_rw(1'b1, acpe_pkg::OFS_LIM_LO, 32'h0000_0900);
    chk_alarm(12'h0A1, 4'h6, 1'b0);
    apb_rw(1'b1, acpe_pkg::OFS_LIM_LO, 32'h0000_0000);
    // Late move after a speed change near the upper limit
    apb_rw(1'b1, acpe_pkg::OFS_STOP, 32'h0000_0100);
    cur_pos_in <= 16'h0780;
    moving_in <= 1'b1;
    speed_change_in <= 1'b1;
    @(posedge pclk);
    speed_change_in <= 1'b0;
    apb_rw(1'b1, acpe_pkg::OFS_MOVE, 32'h0001_0300);
    chk_alarm(12'h0A7, 4'h3, 1'b0);
    moving_in <= 1'b0;
    complete_run();
  end
endmodule : testbench
